// ===== dv/wake_pin_detector_properties.sv
`default_nettype none
module wake_pin_detector_properties
	import wake_pkg::*;
(
	input wire logic              CLK,         // Clock
	input wire logic              RESET,       // Reset
	input wire logic              WAKE_PIN,    // Pin level
	input wire logic              SUPPLY_OFF,  // Supply off
	input wire mode_e             SBC_MODE,    // Chip mode
	input wire logic [ADDR_W-1:0] ADDR,        // Address
	input wire logic [DATA_W-1:0] WDATA,       // Write data
	input wire logic              WR,          // Write strobe
	input wire logic              RD,          // Read strobe
	input wire logic [DATA_W-1:0] RDATA,       // Read data
	input wire logic              IRQ,         // Interrupt
	input wire logic              WAKE_REQ,    // Sleep exit
	input wire logic              RESTART_REQ  // Restart pulse
);
	logic [7:0] stable;
	logic [7:0] next_stable;
	logic       pin_d;
	// Cycles since the pin last moved, saturating
	always_comb begin
		next_stable = stable;
		if (WAKE_PIN != pin_d) begin
			next_stable = 8'h00;
		end else if (stable != 8'hff) begin
			next_stable = stable + 8'h01;
		end
	end
	always_ff @(posedge CLK) begin
		pin_d  <= WAKE_PIN;
		stable <= RESET ? 8'h00 : next_stable;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	// Software writes that must silence the interrupt
	sequence s_mask_all;
		WR && ADDR == MASK_OFS && WDATA[1:0] == 2'h3;
	endsequence
	sequence s_clear_all;
		WR && ADDR == FLAGS_OFS && WDATA[1:0] == 2'h3;
	endsequence
	chk_read_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read slot");
	chk_filter_hold: assert property (RESTART_REQ |-> stable >= 8'h5a)
		else $error("event on a pin level shorter than the filter");
	chk_restart_once: assert property (RESTART_REQ |=> !RESTART_REQ [*8])
		else $error("restart pulse too long");
	chk_restart_mode: assert property (RESTART_REQ |-> $past(SBC_MODE) == MODE_FAILSAFE)
		else $error("restart outside fail-safe");
	chk_wake_mode: assert property (WAKE_REQ |-> $past(SBC_MODE) == MODE_SLEEP)
		else $error("wake request outside sleep");
	chk_supply_quiet: assert property (SUPPLY_OFF && $past(SUPPLY_OFF) |-> !RESTART_REQ)
		else $error("event while supply off");
	chk_mask_irq: assert property (s_mask_all |-> ##2 !IRQ [*4])
		else $error("interrupt despite full mask");
	chk_clear_irq: assert property (s_clear_all |-> ##2 !IRQ)
		else $error("interrupt after flags cleared");
endmodule
`default_nettype wire

// ===== dv/wake_pin_detector_tb.sv
`default_nettype none
module wake_pin_detector_tb
	import wake_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic              level = 1'b0;
	logic              supply_off = 1'b0;
	mode_e             mode = MODE_NORMAL;
	logic [ADDR_W-1:0] addr = 4'h0;
	logic [DATA_W-1:0] wdata = 8'h00;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic              rd_d = 1'b0;
	wire logic         wake_pin;
	logic [DATA_W-1:0] rdata;
	logic              irq;
	logic              wake_req;
	logic              restart_req;
	logic [DATA_W-1:0] exp_q[$];
	logic [3:0]        ofs[6] = '{CTRL_OFS, STATUS_OFS, FLAGS_OFS, MASK_OFS, CAUSE_OFS, 4'hf};
	int                n_mismatch = 0;
	int                check_count = 0;
	int                cyc = 0;
	int                n_wake = 0;
	int                n_restart = 0;
	int                base;
	always #50 clk = ~clk;
	wake_source wake_source_i (.CLK(clk), .LEVEL(level), .WAKE_PIN(wake_pin));
	wake_pin_detector wake_pin_detector_i (.CLK(clk), .RESET(reset), .WAKE_PIN(wake_pin), .SUPPLY_OFF(supply_off),
		.SBC_MODE(mode), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
		.WAKE_REQ(wake_req), .RESTART_REQ(restart_req));
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		check_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic write(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic read(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic move(input logic l, input int n);
		level <= l;
		repeat (n) @(posedge clk);
	endtask
	task automatic look(input logic [7:0] e);
		@(negedge clk);
		check({7'h00, irq}, e);
		@(posedge clk);
	endtask
	// Counts request cycles, times out a hang
	always @(posedge clk) begin
		rd_d <= rd;
		cyc <= cyc + 1;
		n_wake <= n_wake + int'(wake_req);
		n_restart <= n_restart + int'(restart_req);
		if (cyc == 6000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// Read data against the oldest note
	always @(negedge clk) begin
		if (rd_d) begin
			check(rdata, exp_q.pop_front());
		end
	end
	initial begin
		void'($urandom(32'h6d302dd4));
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		foreach (ofs[i]) read(ofs[i], 8'h00);
		write(CTRL_OFS, 8'h01);
		read(CTRL_OFS, 8'h01);
		move(1'b1, 120);
		read(STATUS_OFS, 8'h01);
		read(FLAGS_OFS, 8'h01);
		mode <= MODE_STOP;
		move(1'b0, 120);
		read(FLAGS_OFS, 8'h03);
		read(STATUS_OFS, 8'h00);
		write(MASK_OFS, 8'h01);
		look(8'h01);
		write(MASK_OFS, 8'h03);
		look(8'h00);
		// Keep the full mask while the checker watches the quiet window
		repeat (4) @(posedge clk);
		write(MASK_OFS, 8'h00);
		write(FLAGS_OFS, 8'h01);
		read(FLAGS_OFS, 8'h02);
		look(8'h01);
		write(FLAGS_OFS, 8'h02);
		look(8'h00);
		mode <= MODE_FLASH;
		move(1'b1, 10 + $urandom_range(85));
		move(1'b0, 120);
		read(FLAGS_OFS, 8'h00);
		write(CTRL_OFS, 8'h00);
		move(1'b1, 120);
		read(FLAGS_OFS, 8'h00);
		write(CTRL_OFS, 8'h01);
		move(1'b0, 120);
		mode <= MODE_SLEEP;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check({7'h00, wake_req}, 8'h01);
		@(posedge clk);
		write(FLAGS_OFS, 8'h03);
		read(STATUS_OFS, 8'h00);
		base = n_wake;
		move(1'b1, 120);
		check({7'h00, n_wake > base}, 8'h01);
		read(CAUSE_OFS, 8'h01);
		write(CTRL_OFS, 8'h00);
		base = n_wake;
		move(1'b0, 120);
		check(8'(n_wake - base), 8'h00);
		mode <= MODE_FAILSAFE;
		base = n_restart;
		move(1'b1, 120);
		move(1'b0, 120);
		check(8'(n_restart - base), 8'h02);
		read(CAUSE_OFS, 8'h02);
		supply_off <= 1'b1;
		move(1'b1, 120);
		supply_off <= 1'b0;
		move(1'b1, 120);
		check(8'(n_restart - base), 8'h02);
		mode <= MODE_NORMAL;
		write(FLAGS_OFS, 8'h03);
		mode <= MODE_SLEEP;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check({7'h00, wake_req}, 8'h00);
		end_sim();
	end
endmodule
bind wake_pin_detector wake_pin_detector_properties wake_pin_detector_properties_i (.CLK, .RESET, .WAKE_PIN,
	.SUPPLY_OFF, .SBC_MODE, .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .WAKE_REQ, .RESTART_REQ);
`default_nettype wire

// ===== dv/wake_source.sv
`default_nettype none
module wake_source (
	input  wire logic CLK,      // Bench clock
	input  wire logic LEVEL,    // Requested pin level
	output var  logic WAKE_PIN  // Driven wake pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial WAKE_PIN = 1'b0;
	// Pin moves mid-cycle, away from the detector's sampling edge
	always @(posedge CLK) begin
		WAKE_PIN <= #37 LEVEL;
	end
endmodule
`default_nettype wire

// ===== rtl/wake_filter.sv
`default_nettype none
module wake_filter
	import wake_pkg::*;
(
	input  wire logic CLK,      // System clock
	input  wire logic RESET,    // Synchronous reset
	input  wire logic HOLD,     // Track pin without events
	input  wire logic SAMPLE,   // Synchronised pin level
	output var  logic LEVEL,    // Filtered level
	output var  logic RISE,     // Accepted low to high pulse
	output var  logic FALL      // Accepted high to low pulse
);
	logic [FILTER_CNT_W-1:0] count;
	logic [FILTER_CNT_W-1:0] next_count;
	logic [1:0]              arm;
	logic [1:0]              next_arm;
	logic                    level;
	logic                    next_level;
	logic                    rise;
	logic                    next_rise;
	logic                    fall;
	logic                    next_fall;

	// Count cycles the new level has stood; accept when full
	always_comb begin
		next_count = '0;
		next_arm   = arm;
		next_level = level;
		next_rise  = 1'b0;
		next_fall  = 1'b0;
		if (arm != ARM_CYC) begin
			next_arm   = arm + 2'h1;
			next_level = SAMPLE;
		end else if (HOLD) begin
			next_level = SAMPLE;
		end else if (SAMPLE != level) begin
			if (count == FILTER_CNT_W'(FILTER_CYC - 1)) begin // see (RULE2) (RULE12)
				next_level = SAMPLE;
				next_rise  = SAMPLE;                             // see (RULE1)
				next_fall  = !SAMPLE;                            // see (RULE1)
			end else begin
				next_count = count + FILTER_CNT_W'(1);
			end
		end
	end

	// Register filter state
	always_ff @(posedge CLK) begin
		if (RESET) begin
			count <= '0;
			arm   <= 2'h0;
			level <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else begin
			count <= next_count;
			arm   <= next_arm;
			level <= next_level;
			rise  <= next_rise;
			fall  <= next_fall;
		end
	end

	assign LEVEL = level;
	assign RISE  = rise;
	assign FALL  = fall;
endmodule
`default_nettype wire

// ===== rtl/wake_pin_detector.sv
// How it works
// (RULE1) Both rising and falling accepted changes of the wake input count as wake events.
// (RULE2) A change is accepted only after it stands through the whole filter interval.
// (RULE3) Software sets or clears wake_input_enable in the control register.
// (RULE4) While the supply is off, wake input activity is ignored entirely.
// (RULE5) In Normal, Stop and flash modes status shows filtered wake_level_flag.
// (RULE6) With enable set, any accepted change requests leaving Sleep.
// (RULE7) In Fail-Safe, any accepted change always requests Restart.
// (RULE8) Active modes with enable set raise direction flags and an unmasked interrupt.
// (RULE9) Separate mask bits for low-to-high and high-to-low interrupts.
// (RULE10) Any flag still set in Sleep requests leaving Sleep at once.
// (RULE11) Software should clear both flags before commanding Sleep.
// (RULE12) Pin is synchronised, then must sample stably for the full interval.
//
// Chosen here: the address-and-strobe port and the register offsets.
`default_nettype none
module wake_pin_detector
	import wake_pkg::*;
(
	input  wire logic              CLK,          // 10 MHz system clock
	input  wire logic              RESET,        // Synchronous reset, high
	input  wire logic              WAKE_PIN,     // External wake input
	input  wire logic              SUPPLY_OFF,   // Supply below operating level
	input  wire mode_e             SBC_MODE,     // Current chip mode
	input  wire logic [ADDR_W-1:0] ADDR,         // Register address
	input  wire logic [DATA_W-1:0] WDATA,        // Write data
	input  wire logic              WR,           // Write strobe
	input  wire logic              RD,           // Read strobe
	output var  logic [DATA_W-1:0] RDATA,        // Read data, cycle after RD
	output var  logic              IRQ,          // Interrupt level
	output var  logic              WAKE_REQ,     // Request to leave Sleep
	output var  logic              RESTART_REQ   // Pulse: go to Restart
);
	// Filtered pin signals
	logic       pin_sync;
	logic       wake_level;
	logic       rise_ev;
	logic       fall_ev;
	logic       any_ev;

	// Register state
	logic       wake_input_enable;
	logic       next_wake_input_enable;
	logic [1:0] flags;
	logic [1:0] next_flags;
	logic [1:0] mask;
	logic [1:0] next_mask;
	logic [1:0] cause;
	logic [1:0] next_cause;

	// Output state
	logic              irq;
	logic              next_irq;
	logic              wake_req;
	logic              next_wake_req;
	logic              restart_req;
	logic              next_restart_req;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] next_rdata;

	// Decoded strobes and qualifiers
	logic       wr_ctrl;
	logic       wr_flags;
	logic       wr_mask;
	logic [1:0] flag_set;
	logic [1:0] flag_clr;
	logic       in_sleep;
	logic       in_failsafe;
	logic       sleep_wake;
	logic       fs_wake;

	// True in the modes where the status level bit and flag setting are live
	function automatic logic mode_active(input mode_e m);
		logic r;
		r = 1'b0;
		unique case (m)
			MODE_NORMAL,
			MODE_STOP,
			MODE_FLASH: begin
				r = 1'b1;
			end
			MODE_INIT,
			MODE_SLEEP,
			MODE_FAILSAFE,
			MODE_RESTART: begin
				r = 1'b0;
			end
			default: begin
				r = 1'b0;
			end
		endcase
		return r;
	endfunction

	// True when a write strobe hits the given offset
	function automatic logic wr_hit(input logic we, input logic [ADDR_W-1:0] a,
	                                input logic [ADDR_W-1:0] ofs);
		return we && (a == ofs);
	endfunction

	// Bring the pin into the clock domain
	wake_sync u_sync (
		.CLK    (CLK),
		.RESET  (RESET),
		.PIN    (WAKE_PIN),
		.SYNCED (pin_sync)
	);

	// Glitch filter; held while the supply is off so nothing is seen
	wake_filter u_filter (
		.CLK    (CLK),
		.RESET  (RESET),
		.HOLD   (SUPPLY_OFF),  // see (RULE4)
		.SAMPLE (pin_sync),
		.LEVEL  (wake_level),
		.RISE   (rise_ev),
		.FALL   (fall_ev)
	);

	// Either direction is a wake event
	assign any_ev = rise_ev || fall_ev;  // see (RULE1)

	// Decode register writes
	always_comb begin
		wr_ctrl  = wr_hit(WR, ADDR, CTRL_OFS);
		wr_flags = wr_hit(WR, ADDR, FLAGS_OFS);
		wr_mask  = wr_hit(WR, ADDR, MASK_OFS);
	end

	// Mode qualifiers
	always_comb begin
		in_sleep    = (SBC_MODE == MODE_SLEEP) && !SUPPLY_OFF;     // see (RULE4)
		in_failsafe = (SBC_MODE == MODE_FAILSAFE) && !SUPPLY_OFF;  // see (RULE4)
	end

	// Control register: wake input enable
	always_comb begin
		next_wake_input_enable = wake_input_enable;
		if (wr_ctrl) begin
			next_wake_input_enable = WDATA[ENABLE_BIT];  // see (RULE3)
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			wake_input_enable <= ENABLE_RST;
		end else begin
			wake_input_enable <= next_wake_input_enable;
		end
	end

	// Mask register: one bit per direction, one masks
	always_comb begin
		next_mask = mask;
		if (wr_mask) begin
			next_mask[RISE_BIT] = WDATA[RISE_BIT];  // see (RULE9)
			next_mask[FALL_BIT] = WDATA[FALL_BIT];  // see (RULE9)
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			mask <= MASK_RST;
		end else begin
			mask <= next_mask;
		end
	end

	// Direction flags: set in active modes, write one to clear, set wins
	always_comb begin
		flag_set = 2'h0;
		flag_clr = 2'h0;
		if (wake_input_enable && mode_active(SBC_MODE) && !SUPPLY_OFF) begin  // see (RULE8) (RULE4)
			flag_set[RISE_BIT] = rise_ev;
			flag_set[FALL_BIT] = fall_ev;
		end
		if (wr_flags) begin
			flag_clr = WDATA[1:0];
		end
		next_flags = (flags & ~flag_clr) | flag_set;
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			flags <= FLAGS_RST;
		end else begin
			flags <= next_flags;
		end
	end

	// Wake conditions out of Sleep and Fail-Safe
	always_comb begin
		sleep_wake = in_sleep && wake_input_enable && any_ev;  // see (RULE6)
		fs_wake    = in_failsafe && any_ev;                    // see (RULE7)
	end

	// Leave Sleep on a fresh event or on any flag still pending
	always_comb begin
		next_wake_req = 1'b0;
		if (in_sleep) begin
			next_wake_req = sleep_wake || (flags != 2'h0);  // see (RULE6) (RULE10)
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			wake_req <= 1'b0;
		end else begin
			wake_req <= next_wake_req;
		end
	end

	// One pulse toward Restart per accepted change in Fail-Safe
	always_comb begin
		next_restart_req = fs_wake;  // see (RULE7)
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			restart_req <= 1'b0;
		end else begin
			restart_req <= next_restart_req;
		end
	end

	// Remember which direction last woke the chip
	always_comb begin
		next_cause = cause;
		if (sleep_wake || fs_wake) begin
			next_cause[RISE_BIT] = rise_ev;
			next_cause[FALL_BIT] = fall_ev;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			cause <= CAUSE_RST;
		end else begin
			cause <= next_cause;
		end
	end

	// Interrupt: any unmasked flag, from next state so it tracks flags
	always_comb begin
		next_irq = (next_flags & ~next_mask) != 2'h0;  // see (RULE8) (RULE9)
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// Read data: valid only the cycle after RD, zero otherwise
	always_comb begin
		next_rdata = '0;
		if (RD) begin
			unique case (ADDR)
				CTRL_OFS: begin
					next_rdata[ENABLE_BIT] = wake_input_enable;
				end
				STATUS_OFS: begin
					next_rdata[LEVEL_BIT] = wake_level && mode_active(SBC_MODE);  // see (RULE5)
				end
				FLAGS_OFS: begin
					next_rdata[1:0] = flags;
				end
				MASK_OFS: begin
					next_rdata[1:0] = mask;
				end
				CAUSE_OFS: begin
					next_rdata[1:0] = cause;
				end
				default: begin
					next_rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	// Drive outputs from flops
	assign RDATA       = rdata;
	assign IRQ         = irq;
	assign WAKE_REQ    = wake_req;
	assign RESTART_REQ = restart_req;
endmodule
`default_nettype wire

// ===== rtl/wake_pkg.sv
`default_nettype none
package wake_pkg;
	// Register port widths
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	// Register offsets
	localparam logic [3:0] CTRL_OFS   = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h1;
	localparam logic [3:0] FLAGS_OFS  = 4'h2;
	localparam logic [3:0] MASK_OFS   = 4'h3;
	localparam logic [3:0] CAUSE_OFS  = 4'h4;

	// Field positions
	localparam int unsigned ENABLE_BIT = 0;
	localparam int unsigned LEVEL_BIT  = 0;
	localparam int unsigned RISE_BIT   = 0;
	localparam int unsigned FALL_BIT   = 1;

	// Reset values
	localparam logic       ENABLE_RST = 1'b0;
	localparam logic [1:0] FLAGS_RST  = 2'h0;
	localparam logic [1:0] MASK_RST   = 2'h0;
	localparam logic [1:0] CAUSE_RST  = 2'h0;

	// Timing: clock period and filter interval bounds in ns
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned FILTER_MIN_NS = 10000;
	localparam int unsigned FILTER_MAX_NS = 25000;
	// Least time, rounded up to whole cycles
	localparam int unsigned FILTER_CYC    = (FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FILTER_CNT_W  = 7;
	// Cycles until the synchroniser holds a real pin sample
	localparam logic [1:0]  ARM_CYC       = 2'h3;

	// Chip operating modes
	typedef enum logic [2:0] {
		MODE_INIT,
		MODE_NORMAL,
		MODE_STOP,
		MODE_FLASH,
		MODE_SLEEP,
		MODE_FAILSAFE,
		MODE_RESTART
	} mode_e;
endpackage
`default_nettype wire

// ===== rtl/wake_sync.sv
`default_nettype none
module wake_sync
	import wake_pkg::*;
(
	input  wire logic CLK,      // System clock
	input  wire logic RESET,    // Synchronous reset
	input  wire logic PIN,      // Asynchronous pin level
	output var  logic SYNCED    // Level after two flops
);
	logic stage1;
	logic stage2;
	logic next_stage1;
	logic next_stage2;

	// Shift the pin through two flops
	always_comb begin
		next_stage1 = PIN;
		next_stage2 = stage1;
	end

	// Register the chain
	always_ff @(posedge CLK) begin
		if (RESET) begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			stage2 <= next_stage2;
		end
	end

	assign SYNCED = stage2;
endmodule
`default_nettype wire
